/* File: ang_consts.svh */
// constants for the acquisition noise gate: offsets, fields, times
// assumes a 10 MHz sequencer clock; times in ns, counts derived
`ifndef ANG_CONSTS_SVH
`define ANG_CONSTS_SVH
// ==========================================
// register map
`define ANG_ADDR_CTRL1 4'h1
`define ANG_ADDR_CTRL2 4'h2
`define ANG_ADDR_STAT  4'h3
`define ANG_ADDR_RES   4'h4
`define ANG_CTRL1_RST  16'h0000
`define ANG_CTRL2_RST  16'h0000
// ==========================================
// field positions
`define ANG_POL_BIT    3
`define ANG_START_BIT  15
`define ANG_ACQ_LO     0
`define ANG_SET_LO     4
`define ANG_TOUCH_LAST 4'h3
// ==========================================
// timing
`define ANG_CLK_NS     100
`define ANG_CYC_UP(ns) (((ns) + `ANG_CLK_NS - 1) / `ANG_CLK_NS)
`define ANG_ACQ0_NS    2000
`define ANG_ACQ1_NS    4000
`define ANG_ACQ2_NS    8000
`define ANG_ACQ3_NS    16000
`define ANG_SET0_NS    500
`define ANG_SET1_NS    128000000
`define ANG_SET2_NS    1024000
`define ANG_SET3_NS    8190000
`define ANG_CONV_CYC   13
`define ANG_CNT_W      21
`endif

/* File: ang_pkg.sv */
// types shared by the acquisition noise gate
// state codes and bus field widths are set here, not taken from ang_consts.svh
package ang_pkg;
  typedef enum logic [2:0] {
    ANG_IDLE   = 3'h0,
    ANG_SETTLE = 3'h1,
    ANG_WAIT   = 3'h2,
    ANG_ACQ    = 3'h3,
    ANG_CONV   = 3'h4
  } ang_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ang_bus_t;
endpackage

/* File: ang_noise_gate.sv */
// sequencer gate that keeps acquisitions out of display noise windows
// assumes one 10 MHz clock, a register port on that clock and an
// asynchronous hold pin from the display controller
//
// Functional notes
// - no acquisition while hold is active
// - hold release restarts acquisition of due channel
// - polarity bit is bit 3 at 02h
// - polarity 0 active low, 1 active high
// - polarity bit resets to zero
// - hold aborts acquisition, full restart after
// - acquisition time 2, 4, 8, 16 us
// - conversion completes, next acquisition waits
// - settling delay before sequence and touch channels
// - settling delay ignores hold input
// - gate covers every input channel
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ang_consts.svh"

module ang_noise_gate #(
  parameter logic [20:0] SETTLE1_CYC = 21'(`ANG_CYC_UP(`ANG_SET1_NS)),
  parameter logic [20:0] SETTLE2_CYC = 21'(`ANG_CYC_UP(`ANG_SET2_NS)),
  parameter logic [20:0] SETTLE3_CYC = 21'(`ANG_CYC_UP(`ANG_SET3_NS))
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // register port
  input  wire ang_pkg::ang_bus_t bus_i,
  output logic [15:0]           rdata_o,
  // display timing pin
  input  wire logic             acq_hold_input_i,
  // converter core
  input  wire logic [11:0]      conv_data_i,
  output logic                  acq_o,
  output logic                  conv_o,
  output logic [3:0]            channel_o,
  output logic                  busy_o,
  output logic                  done_o
);

  // ==========================================
  // helpers
  function automatic logic [20:0] acq_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: acq_len = 21'(`ANG_CYC_UP(`ANG_ACQ0_NS));
      2'h1: acq_len = 21'(`ANG_CYC_UP(`ANG_ACQ1_NS));
      2'h2: acq_len = 21'(`ANG_CYC_UP(`ANG_ACQ2_NS));
      2'h3: acq_len = 21'(`ANG_CYC_UP(`ANG_ACQ3_NS));
    endcase
  endfunction

  function automatic logic [20:0] settle_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: settle_len = 21'(`ANG_CYC_UP(`ANG_SET0_NS));
      2'h1: settle_len = SETTLE1_CYC;
      2'h2: settle_len = SETTLE2_CYC;
      2'h3: settle_len = SETTLE3_CYC;
    endcase
  endfunction

  function automatic logic is_touch(input logic [3:0] ch);
    is_touch = (ch <= `ANG_TOUCH_LAST);
  endfunction

  // ==========================================
  // state
  logic                hold_s1_reg;
  logic                hold_s2_reg;
  logic [15:0]         ctrl1_reg;
  logic [15:0]         ctrl2_reg;
  logic [11:0]         result_reg;
  ang_pkg::ang_state_t state_reg;
  ang_pkg::ang_state_t state_next;
  logic [20:0]         cnt_reg;
  logic [20:0]         cnt_next;
  logic [3:0]          chan_reg;
  logic [3:0]          chan_next;

  // ==========================================
  // decode
  wire        hold_polarity = ctrl2_reg[`ANG_POL_BIT];
  wire        hold_active   = ~(hold_s2_reg ^ hold_polarity);
  wire        wr_ctrl1      = bus_i.wr && (bus_i.addr == `ANG_ADDR_CTRL1);
  wire        wr_ctrl2      = bus_i.wr && (bus_i.addr == `ANG_ADDR_CTRL2);
  wire        start         = wr_ctrl1 && bus_i.wdata[`ANG_START_BIT];
  wire [20:0] acq_cnt       = acq_len(ctrl2_reg[`ANG_ACQ_LO +: 2]) - 21'h1;
  wire [20:0] settle_cnt    = settle_len(ctrl2_reg[`ANG_SET_LO +: 2]) - 21'h1;
  wire [20:0] conv_cnt      = 21'(`ANG_CONV_CYC - 1);
  wire        cnt_zero      = (cnt_reg == 21'h0);
  wire [20:0] cnt_dec       = cnt_reg - 21'h1;
  wire        last_chan     = (chan_reg == ctrl1_reg[7:4]);
  wire [3:0]  chan_inc      = chan_reg + 4'h1;
  wire        conv_end      = (state_reg == ang_pkg::ANG_CONV) && cnt_zero;
  wire [15:0] stat_word     = {8'h00, hold_active, state_reg, chan_reg};

  logic [15:0] rd_mux;
  assign rd_mux = (bus_i.addr == `ANG_ADDR_CTRL1) ? ctrl1_reg :
                  (bus_i.addr == `ANG_ADDR_CTRL2) ? ctrl2_reg :
                  (bus_i.addr == `ANG_ADDR_STAT)  ? stat_word :
                  (bus_i.addr == `ANG_ADDR_RES)   ? {4'h0, result_reg} : 16'h0000;

  // ==========================================
  // hold pin synchroniser
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
    end else begin
      hold_s1_reg <= acq_hold_input_i;
      hold_s2_reg <= hold_s1_reg;
    end
  end

  // ==========================================
  // registers; start bit is a strobe and is not kept
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl1_reg <= `ANG_CTRL1_RST;
      ctrl2_reg <= `ANG_CTRL2_RST;
      rdata_o   <= 16'h0000;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_reg <= {1'b0, bus_i.wdata[14:0]};
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= bus_i.wdata;
      end
      rdata_o <= bus_i.rd ? rd_mux : 16'h0000;
    end
  end

  // ==========================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    chan_next  = chan_reg;
    unique case (state_reg)
      ang_pkg::ANG_IDLE: begin
        if (start) begin
          chan_next  = bus_i.wdata[3:0];
          state_next = ang_pkg::ANG_SETTLE;
          cnt_next   = settle_cnt;
        end
      end
      ang_pkg::ANG_SETTLE: begin
        // hold is not looked at until the delay runs out
        if (!cnt_zero) begin
          cnt_next = cnt_dec;
        end else if (hold_active) begin
          state_next = ang_pkg::ANG_WAIT;
        end else begin
          state_next = ang_pkg::ANG_ACQ;
          cnt_next   = acq_cnt;
        end
      end
      ang_pkg::ANG_WAIT: begin
        if (!hold_active) begin
          state_next = ang_pkg::ANG_ACQ;
          cnt_next   = acq_cnt;
        end
      end
      ang_pkg::ANG_ACQ: begin
        // channel-independent: every channel passes through here
        if (hold_active) begin
          state_next = ang_pkg::ANG_WAIT;
        end else if (!cnt_zero) begin
          cnt_next = cnt_dec;
        end else begin
          state_next = ang_pkg::ANG_CONV;
          cnt_next   = conv_cnt;
        end
      end
      ang_pkg::ANG_CONV: begin
        if (!cnt_zero) begin
          cnt_next = cnt_dec;
        end else if (last_chan) begin
          state_next = ang_pkg::ANG_IDLE;
        end else begin
          chan_next = chan_inc;
          if (is_touch(chan_inc)) begin
            state_next = ang_pkg::ANG_SETTLE;
            cnt_next   = settle_cnt;
          end else if (hold_active) begin
            state_next = ang_pkg::ANG_WAIT;
          end else begin
            state_next = ang_pkg::ANG_ACQ;
            cnt_next   = acq_cnt;
          end
        end
      end
      default: begin
        state_next = ang_pkg::ANG_IDLE;
      end
    endcase
  end

  // outputs other than done_o follow the next state so they leave a flop with no lag; done_o registers conv_end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg  <= ang_pkg::ANG_IDLE;
      cnt_reg    <= 21'h0;
      chan_reg   <= 4'h0;
      result_reg <= 12'h000;
      acq_o      <= 1'b0;
      conv_o     <= 1'b0;
      channel_o  <= 4'h0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      chan_reg  <= chan_next;
      if (conv_end) begin
        result_reg <= conv_data_i;
      end
      acq_o     <= (state_next == ang_pkg::ANG_ACQ);
      conv_o    <= (state_next == ang_pkg::ANG_CONV);
      channel_o <= chan_next;
      busy_o    <= (state_next != ang_pkg::ANG_IDLE);
      done_o    <= conv_end;
    end
  end

  // ==========================================
  // checks
  logic [7:0] acq_run_reg;
  logic       seen_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acq_run_reg <= 8'h00;
      seen_reg    <= 1'b0;
    end else begin
      acq_run_reg <= (state_reg == ang_pkg::ANG_ACQ) ? acq_run_reg + 8'h01 : 8'h00;
      seen_reg    <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sync_chain_a: assert property (
    hold_s2_reg == $past(hold_s1_reg)) else $error("hold sync skipped a stage");
  hold_blocks_acq_a: assert property (
    hold_active |=> !acq_o) else $error("acquisition during hold");
  resume_acq_a: assert property (
    (state_reg == ang_pkg::ANG_WAIT) && !hold_active |=> state_reg == ang_pkg::ANG_ACQ)
    else $error("no restart after hold release");
  pol_write_a: assert property (
    wr_ctrl2 |=> hold_polarity == $past(bus_i.wdata[`ANG_POL_BIT]))
    else $error("polarity bit not written");
  pol_low_a: assert property (
    !hold_polarity && !hold_s2_reg && (state_reg == ang_pkg::ANG_ACQ)
    |=> state_reg == ang_pkg::ANG_WAIT) else $error("active low hold ignored");
  pol_reset_a: assert property (
    !seen_reg |-> !hold_polarity) else $error("polarity not zero after reset");
  // the run counter still counts the aborted cycle, so it clears one cycle into the wait
  abort_acq_a: assert property (
    (state_reg == ang_pkg::ANG_ACQ) && hold_active
    |=> ((state_reg == ang_pkg::ANG_WAIT) && !acq_o) ##1 (acq_run_reg == 8'h00))
    else $error("acquisition not aborted");
  acq_len_a: assert property (
    (state_reg == ang_pkg::ANG_ACQ) && (state_next == ang_pkg::ANG_CONV)
    |-> 21'(acq_run_reg) == acq_cnt) else $error("acquisition length wrong");
  conv_done_a: assert property (
    (state_reg == ang_pkg::ANG_CONV) && !cnt_zero |=> state_reg == ang_pkg::ANG_CONV)
    else $error("conversion cut short");
  settle_load_a: assert property (
    (state_reg == ang_pkg::ANG_IDLE) && start
    |=> (state_reg == ang_pkg::ANG_SETTLE) && (cnt_reg == $past(settle_cnt)))
    else $error("settling delay not started");
  settle_ign_a: assert property (
    (state_reg == ang_pkg::ANG_SETTLE) && !cnt_zero |=> state_reg == ang_pkg::ANG_SETTLE)
    else $error("settling delay disturbed");
  settle_wait_a: assert property (
    (state_reg == ang_pkg::ANG_SETTLE) && cnt_zero && hold_active
    |=> state_reg == ang_pkg::ANG_WAIT) else $error("first acquisition under hold");

endmodule

/* File: ang_hold_src.sv */
// display controller stand-in: drives the noise framing pin
// assumes the bench says when the display is noisy and which level frames it
`timescale 1ns/1ps

module ang_hold_src (
  // control from bench
  input  wire logic polarity_i,
  input  wire logic noisy_i,
  // pin to the gate
  output logic      hold_pin_o
);
  // ==========================================
  // pin level
  // quiet periods sit at the inactive level
  assign hold_pin_o = noisy_i ? polarity_i : ~polarity_i;
endmodule

/* File: tb_top.sv */
// self-checking bench for the acquisition noise gate
// assumes small settle counts; reads go through a queue of expected data
`timescale 1ns/1ps
`include "ang_consts.svh"

module tb_top;
  logic              clock_i;
  logic              rst_n_i;
  logic              noisy;
  logic              pol_m;
  logic              hold_pin;
  logic              rd_pend;
  ang_pkg::ang_bus_t bus;
  logic [11:0]       cdata;
  logic [15:0]       rdata_o;
  logic [15:0]       d;
  logic              acq_o;
  logic              conv_o;
  logic              busy_o;
  logic              done_o;
  logic [3:0]        channel_o;
  logic [15:0]       exp_q[$];
  int                err_count;
  int                compares;
  int                cyc;
  int                n;
  int                k;

  ang_noise_gate #(.SETTLE1_CYC(21'h8), .SETTLE2_CYC(21'hC), .SETTLE3_CYC(21'h10))
    ang_noise_gate_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .rdata_o(rdata_o), .acq_hold_input_i(hold_pin), .conv_data_i(cdata), .acq_o(acq_o),
    .conv_o(conv_o), .channel_o(channel_o), .busy_o(busy_o), .done_o(done_o));
  ang_hold_src ang_hold_src_inst (.polarity_i(pol_m), .noisy_i(noisy), .hold_pin_o(hold_pin));

  // ==========================================
  // helpers
  function automatic int scyc(input int c);
    return (c == 0) ? 5 : (c == 1) ? 8 : (c == 2) ? 12 : 16;
  endfunction
  function automatic logic sig(input int s);
    return (s == 0) ? acq_o : (s == 1) ? conv_o : done_o;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic wait_sig(input int s, input logic v, output int cnt);
    cnt = 0;
    while (sig(s) !== v && cnt < 3000) begin
      tick();
      cnt++;
    end
    // a wait that runs out must not slip through to the verdict
    chk(16'(sig(s)), 16'(v));
  endtask
  task automatic set_hold(input logic v);
    @(posedge clock_i);
    noisy <= v;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_i);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge clock_i);
    bus.wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    exp_q.push_back(v);
    @(posedge clock_i);
    bus.rd   <= 1'b0;
  endtask
  // configure, start, hold the pin for h cycles, check the settle length when h is shorter than it
  task automatic run(input logic [3:0] f, input logic [3:0] l, input logic [1:0] st,
                     input logic [1:0] ac, input logic p, input int h);
    pol_m <= p;
    cdata <= 12'($urandom);
    wr(`ANG_ADDR_CTRL2, {10'h0, st, p, 1'b0, ac});
    wr(`ANG_ADDR_CTRL1, {1'b1, 7'h0, l, f});
    fork
      if (h > 0) begin
        noisy <= 1'b1;
        repeat (h) @(posedge clock_i);
        noisy <= 1'b0;
      end
    join_none
    #1;
    wait_sig(0, 1'b1, n);
    if (h < scyc(st)) chk(16'(n), 16'(scyc(st)));
    chk(channel_o, f);
  endtask
  task automatic complete_run();
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // clock, read monitor, timeout
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) rd_pend <= bus.rd;
  always @(negedge clock_i) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) chk(rdata_o, exp_q.pop_front());
    else if (rd_pend === 1'b0) chk(rdata_o, 16'h0000);
  end
  // whole run is well under two thousand cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 8000) begin
      chk(16'(cyc), 16'h0000);
      complete_run();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    rst_n_i = 1'b0;
    bus     = '0;
    noisy   = 1'b0;
    pol_m   = 1'b0;
    cdata   = '0;
    void'($urandom(32'hc92a33f4));
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(`ANG_ADDR_CTRL2, 16'h0000);
    d = 16'($urandom);
    wr(`ANG_ADDR_CTRL2, d);
    rd(`ANG_ADDR_CTRL2, d);
    rd(4'h0, 16'h0000);
    for (k = 5; k < 16; k++) rd(4'(k), 16'h0000);
    for (k = 0; k < 4; k++) begin
      run(4'(8 + k), 4'(8 + k), 2'h0, 2'(k), 1'b1, 0);
      wait_sig(0, 1'b0, n);
      chk(16'(n), 16'(20 << k));
      wait_sig(2, 1'b1, n);
      rd(`ANG_ADDR_RES, {4'h0, cdata});
    end
    for (k = 1; k < 4; k++) begin
      run(4'h4, 4'h4, 2'(k), 2'h0, 1'b1, scyc(k) - 6);
      wait_sig(2, 1'b1, n);
    end
    run(4'h4, 4'h4, 2'h3, 2'h0, 1'b1, 26);
    chk(16'(n >= 27 && n <= 32), 16'h0001);
    wait_sig(2, 1'b1, n);
    // hold arrives mid acquisition on a touch channel, active low
    run(4'h0, 4'h0, 2'h0, 2'h1, 1'b0, 0);
    repeat (10) tick();
    set_hold(1'b1);
    wait_sig(0, 1'b0, n);
    chk(16'(n <= 5), 16'h0001);
    k = 0;
    repeat (30) begin
      tick();
      if (acq_o !== 1'b0 || conv_o !== 1'b0) k++;
    end
    chk(16'(k), 16'h0000);
    chk(16'(busy_o), 16'h0001);
    rd(`ANG_ADDR_STAT, 16'h00A0);
    set_hold(1'b0);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    chk(16'(n), 16'h0028);
    chk(channel_o, 4'h0);
    wait_sig(2, 1'b1, n);
    // hold arrives in a conversion; one conversion cycle already elapsed
    run(4'h4, 4'h5, 2'h0, 2'h0, 1'b1, 0);
    wait_sig(1, 1'b1, n);
    set_hold(1'b1);
    wait_sig(1, 1'b0, n);
    chk(16'(n), 16'h000C);
    k = 0;
    repeat (20) begin
      tick();
      if (acq_o !== 1'b0) k++;
    end
    chk(16'(k), 16'h0000);
    set_hold(1'b0);
    wait_sig(0, 1'b1, n);
    chk(channel_o, 4'h5);
    wait_sig(0, 1'b0, n);
    chk(16'(n), 16'h0014);
    wait_sig(2, 1'b1, n);
    chk(16'(busy_o), 16'h0000);
    repeat (4) tick();
    complete_run();
  end
endmodule
